// ---- dit_idle_trap.sv ----
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
// Function
// - device two idle enable loads, expiry raises smi
// - address hit reloads running idle counter
// - trap enable raises smi per hit
// - 16-bit idle counters, one-second decrement
// - 32-bit base compared against bus address
// - io mode bits 6/5 gate writes/reads
// - io mode bits 4:0 mask address 4:0
// - memory mode masks a15:9, ignores a8:0
// - mask bit one ignores that address bit
// - device three mirrors device two, own registers
// - idle expiry sets top bit0, 85h bits
// - user trap sets top bit9, trap bits 3/4
// - video idle timer, video access reloads
// - video trap, second-level bit7 of 86h
// - video access from serial bit or vga ranges
// - vga enable starts 8-bit counter, smi at zero
// - 8Bh bit6 selects 1 ms or 32 us
// - vga reload only by disable then enable
// - vga expiry reports only top bit6
// - vga counter ignores global power enable
module dit_idle_trap #(
   parameter int unsigned SEC_CYCLES = dit_pkg::SEC_CYCLES,
   parameter int unsigned MS_CYCLES  = dit_pkg::MS_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic [9:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [3:0]          avs_byteenable,
   input  wire logic [31:0]         avs_writedata,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   input  wire logic                acc_valid,
   input  wire dit_pkg::dit_access_t acc,
   input  wire logic                processor_serial_activity,
   output logic                     smi_active
);
   localparam int SW = $clog2(SEC_CYCLES);
   localparam int MW = $clog2(MS_CYCLES);
   localparam int FW = $clog2(dit_pkg::FAST_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] wb8(input logic [7:0] o,
                                      input logic [31:0] w,
                                      input logic [3:0] be);
      wb8 = be[0] ? w[7:0] : o;
   endfunction

   function automatic logic [15:0] wb16(input logic [15:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0] be);
      wb16 = {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
   endfunction

   function automatic logic [31:0] wb32(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
         if (be[b])
            r[b*8 +: 8] = w[b*8 +: 8];
      wb32 = r;
   endfunction

   // address match for one user device
   function automatic logic dev_match(input logic [31:0] base,
                                      input logic [7:0] ctl,
                                      input dit_pkg::dit_access_t a);
      logic [31:0] diff;
      logic        ok;
      diff = a.addr ^ base;
      if (ctl[dit_pkg::CTL_MEM_BIT])
      begin
         ok = a.mem && diff[31:16] == 16'h0000 &&
              (diff[15:9] & ~ctl[6:0]) == 7'h00;
      end
      else
      begin
         ok = !a.mem && diff[31:5] == 27'h0 &&
              (diff[4:0] & ~ctl[4:0]) == 5'h00 &&
              (a.write ? ctl[dit_pkg::CTL_WR_BIT]
                       : ctl[dit_pkg::CTL_RD_BIT]);
      end
      dev_match = ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle on every access
   logic        done_q;
   logic [31:0] rd_q;
   logic [31:0] rd_d;
   wire  [7:0]  idx     = avs_address[9:2];
   wire         req     = avs_read | avs_write;
   wire         wr_fire = avs_write & done_q;

   assign avs_waitrequest = req & ~done_q;
   assign avs_readdata    = rd_q;

   logic [7:0]  en2_q;
   logic [7:0]  en3_q;
   logic [7:0]  en4_q;
   logic [7:0]  gpt2_q;
   logic [7:0]  vload_q;
   logic [15:0] cnt_reg_q [3];
   logic [31:0] base_q [2];
   logic [7:0]  ctl_q [2];
   logic [9:0]  top_q;
   logic [7:0]  idle_sl_q;
   logic [7:0]  trap_sl_q;
   logic [7:0]  utrap_q;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         done_q <= 1'b0;
         rd_q   <= 32'h00000000;
      end
      else
      begin
         done_q <= req & ~done_q;
         if (avs_read & ~done_q)
            rd_q <= rd_d;
      end
   end

   always_comb
   begin
      rd_d = 32'h00000000;
      case (idx)
         dit_pkg::IDX_EN_TWO:     rd_d[7:0]  = en2_q;
         dit_pkg::IDX_EN_THREE:   rd_d[7:0]  = en3_q;
         dit_pkg::IDX_EN_FOUR:    rd_d[7:0]  = en4_q;
         dit_pkg::IDX_IDLE_STS:   rd_d[7:0]  = idle_sl_q;
         dit_pkg::IDX_TRAP_STS:   rd_d[7:0]  = trap_sl_q;
         dit_pkg::IDX_GPT2_CTL:   rd_d[7:0]  = gpt2_q;
         dit_pkg::IDX_VGA_LOAD:   rd_d[7:0]  = vload_q;
         dit_pkg::IDX_CNT_TWO:    rd_d[15:0] = cnt_reg_q[0];
         dit_pkg::IDX_CNT_THREE:  rd_d[15:0] = cnt_reg_q[1];
         dit_pkg::IDX_CNT_VIDEO:  rd_d[15:0] = cnt_reg_q[2];
         dit_pkg::IDX_BASE_TWO:   rd_d       = base_q[0];
         dit_pkg::IDX_BASE_THREE: rd_d       = base_q[1];
         dit_pkg::IDX_CTL_TWO:    rd_d[7:0]  = ctl_q[0];
         dit_pkg::IDX_CTL_THREE:  rd_d[7:0]  = ctl_q[1];
         dit_pkg::IDX_TOP_STS:    rd_d[9:0]  = top_q;
         dit_pkg::IDX_UDEV_TRAP:  rd_d[7:0]  = utrap_q;
         default:                 rd_d       = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers; count and load register writes never reload a timer by themselves
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         en2_q   <= dit_pkg::REG_RESET;
         en3_q   <= dit_pkg::REG_RESET;
         en4_q   <= dit_pkg::REG_RESET;
         gpt2_q  <= dit_pkg::REG_RESET;
         vload_q <= dit_pkg::REG_RESET;
         for (int i = 0; i < 3; i++)
            cnt_reg_q[i] <= 16'h0000;
         for (int i = 0; i < 2; i++)
         begin
            base_q[i] <= 32'h00000000;
            ctl_q[i]  <= dit_pkg::REG_RESET;
         end
      end
      else if (wr_fire)
      begin
         case (idx)
            dit_pkg::IDX_EN_TWO:
               en2_q <= wb8(en2_q, avs_writedata, avs_byteenable);
            dit_pkg::IDX_EN_THREE:
               en3_q <= wb8(en3_q, avs_writedata, avs_byteenable);
            dit_pkg::IDX_EN_FOUR:
               en4_q <= wb8(en4_q, avs_writedata, avs_byteenable);
            dit_pkg::IDX_GPT2_CTL:
               gpt2_q <= wb8(gpt2_q, avs_writedata, avs_byteenable);
            dit_pkg::IDX_VGA_LOAD:
               vload_q <= wb8(vload_q, avs_writedata, avs_byteenable);
            dit_pkg::IDX_CNT_TWO:
               cnt_reg_q[0] <= wb16(cnt_reg_q[0], avs_writedata,
                                    avs_byteenable);
            dit_pkg::IDX_CNT_THREE:
               cnt_reg_q[1] <= wb16(cnt_reg_q[1], avs_writedata,
                                    avs_byteenable);
            dit_pkg::IDX_CNT_VIDEO:
               cnt_reg_q[2] <= wb16(cnt_reg_q[2], avs_writedata,
                                    avs_byteenable);
            dit_pkg::IDX_BASE_TWO:
               base_q[0] <= wb32(base_q[0], avs_writedata, avs_byteenable);
            dit_pkg::IDX_BASE_THREE:
               base_q[1] <= wb32(base_q[1], avs_writedata, avs_byteenable);
            dit_pkg::IDX_CTL_TWO:
               ctl_q[0] <= wb8(ctl_q[0], avs_writedata, avs_byteenable);
            dit_pkg::IDX_CTL_THREE:
               ctl_q[1] <= wb8(ctl_q[1], avs_writedata, avs_byteenable);
            default:
               en2_q <= en2_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timebases; free running so a tick may come early after a load
   logic [SW-1:0] sec_q;
   logic [MW-1:0] ms_q;
   logic [FW-1:0] fast_q;
   wire sec_tick  = sec_q == SW'(SEC_CYCLES - 1);
   wire ms_tick   = ms_q == MW'(MS_CYCLES - 1);
   wire fast_tick = fast_q == FW'(dit_pkg::FAST_CYCLES - 1);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sec_q  <= '0;
         ms_q   <= '0;
         fast_q <= '0;
      end
      else
      begin
         sec_q  <= sec_tick ? '0 : sec_q + 1'b1;
         ms_q   <= ms_tick ? '0 : ms_q + 1'b1;
         fast_q <= fast_tick ? '0 : fast_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // activity decode; the serial pin is synchronised first
   logic [2:0] ser_q;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         ser_q <= 3'h0;
      else
         ser_q <= {ser_q[1:0], processor_serial_activity};
   end

   wire [11:0] io_grp = acc.addr[15:4];
   wire vga_io  = !acc.mem && (io_grp == dit_pkg::VGA_IO_MONO ||
                  io_grp == dit_pkg::VGA_IO_ATTR ||
                  io_grp == dit_pkg::VGA_IO_COLOR);
   wire vga_mem = acc.mem && acc.addr >= dit_pkg::VGA_MEM_LO &&
                  acc.addr <= dit_pkg::VGA_MEM_HI;
   wire video_hit = (ser_q[1] & ~ser_q[2]) |
                    (acc_valid & (vga_io | vga_mem));
   wire [2:0] act = {video_hit,
                     acc_valid & dev_match(base_q[1], ctl_q[1], acc),
                     acc_valid & dev_match(base_q[0], ctl_q[0], acc)};
   wire [2:0] idle_en  = en2_q[dit_pkg::EN_IDLE_LSB +: 3];
   wire [2:0] trap_hit = act & en3_q[dit_pkg::EN_IDLE_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////
   // idle timers: 0 device two, 1 device three, 2 video
   logic [15:0] icnt_q [3];
   logic [15:0] icnt_d [3];
   logic [2:0]  irun_q;
   logic [2:0]  irun_d;
   logic [2:0]  ien_prev_q;
   logic [2:0]  idle_exp;
   wire  [2:0]  irise = idle_en & ~ien_prev_q;

   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         icnt_d[i]   = icnt_q[i];
         irun_d[i]   = irun_q[i];
         idle_exp[i] = 1'b0;
         if (!idle_en[i])
         begin
            icnt_d[i] = 16'h0000;
            irun_d[i] = 1'b0;
         end
         else if (act[i] | irise[i])
         begin
            icnt_d[i] = cnt_reg_q[i];
            irun_d[i] = 1'b1;
         end
         else if (irun_q[i] & sec_tick)
         begin
            if (icnt_q[i] <= 16'h0001)
            begin
               icnt_d[i]   = 16'h0000;
               irun_d[i]   = 1'b0;
               idle_exp[i] = 1'b1;
            end
            else
               icnt_d[i] = icnt_q[i] - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         irun_q     <= 3'h0;
         ien_prev_q <= 3'h0;
         for (int i = 0; i < 3; i++)
            icnt_q[i] <= 16'h0000;
      end
      else
      begin
         irun_q     <= irun_d;
         ien_prev_q <= idle_en;
         icnt_q     <= icnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // vga timer; no global power enable input reaches it
   dit_pkg::dit_vga_state_t vst_q;
   dit_pkg::dit_vga_state_t vst_d;
   logic [7:0] vcnt_q;
   logic [7:0] vcnt_d;
   logic       ven_prev_q;
   logic       vga_exp;
   wire vga_en   = en4_q[dit_pkg::EN_VGA_BIT];
   wire vga_rise = vga_en & ~ven_prev_q;
   wire vga_tick = gpt2_q[dit_pkg::VGA_BASE_BIT] ? fast_tick
                                                 : ms_tick;

   always_comb
   begin
      vst_d   = vst_q;
      vcnt_d  = vcnt_q;
      vga_exp = 1'b0;
      case (vst_q)
         dit_pkg::VGA_OFF:
            if (vga_rise)
            begin
               vcnt_d = vload_q;
               vst_d  = dit_pkg::VGA_RUN;
            end
         dit_pkg::VGA_RUN:
            if (!vga_en)
               vst_d = dit_pkg::VGA_OFF;
            else if (vga_tick)
            begin
               if (vcnt_q <= 8'h01)
               begin
                  vcnt_d  = 8'h00;
                  vst_d   = dit_pkg::VGA_DONE;
                  vga_exp = 1'b1;
               end
               else
                  vcnt_d = vcnt_q - 8'h01;
            end
         dit_pkg::VGA_DONE:
            if (!vga_en)
               vst_d = dit_pkg::VGA_OFF;
         default:
            vst_d = dit_pkg::VGA_OFF;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         vst_q      <= dit_pkg::VGA_OFF;
         vcnt_q     <= 8'h00;
         ven_prev_q <= 1'b0;
      end
      else
      begin
         vst_q      <= vst_d;
         vcnt_q     <= vcnt_d;
         ven_prev_q <= vga_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status, write one to clear; a same-cycle set wins
   // all inputs are arguments, so the wires that call it follow the bus
   function automatic logic [9:0] clr_mask(input logic [7:0] sel,
                                           input logic [7:0] at,
                                           input logic       fire,
                                           input logic [9:0] bits);
      clr_mask = (fire && at == sel) ? bits : 10'h000;
   endfunction
   wire  [9:0] wr_bits = {avs_byteenable[1] ? avs_writedata[9:8] : 2'b00,
                          avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

   logic [9:0] top_set;
   logic [7:0] idle_set;
   logic [7:0] trap_set;
   logic [7:0] utrap_set;
   wire  [9:0] clr_top   = clr_mask(dit_pkg::IDX_TOP_STS, idx, wr_fire,
                                    wr_bits);
   wire  [9:0] clr_idle  = clr_mask(dit_pkg::IDX_IDLE_STS, idx, wr_fire,
                                    wr_bits);
   wire  [9:0] clr_trap  = clr_mask(dit_pkg::IDX_TRAP_STS, idx, wr_fire,
                                    wr_bits);
   wire  [9:0] clr_utrap = clr_mask(dit_pkg::IDX_UDEV_TRAP, idx, wr_fire,
                                    wr_bits);
   wire  [9:0] top_d = (top_q & ~clr_top) | top_set;

   always_comb
   begin
      top_set   = 10'h000;
      idle_set  = 8'h00;
      trap_set  = 8'h00;
      utrap_set = 8'h00;
      top_set[dit_pkg::TOP_IDLE_BIT] = |idle_exp | trap_hit[2];
      top_set[dit_pkg::TOP_TRAP_BIT] = |trap_hit[1:0];
      top_set[dit_pkg::TOP_VGA_BIT]  = vga_exp;
      idle_set[dit_pkg::SL_IDLE_LSB +: 3]  = idle_exp;
      trap_set[dit_pkg::SL_VTRAP_BIT]      = trap_hit[2];
      utrap_set[dit_pkg::SL_UTRAP_LSB +: 2] = trap_hit[1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         top_q      <= 10'h000;
         idle_sl_q  <= 8'h00;
         trap_sl_q  <= 8'h00;
         utrap_q    <= 8'h00;
         smi_active <= 1'b0;
      end
      else
      begin
         top_q      <= top_d;
         idle_sl_q  <= (idle_sl_q & ~clr_idle[7:0]) | idle_set;
         trap_sl_q  <= (trap_sl_q & ~clr_trap[7:0]) | trap_set;
         utrap_q    <= (utrap_q & ~clr_utrap[7:0]) | utrap_set;
         smi_active <= |top_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_idle_expiry_status: assert property (idle_exp[0] |=>
      idle_sl_q[5] && top_q[0] && smi_active)
      else $error("idle expiry status missing");
   chk_idle_hit_reload: assert property (act[0] && idle_en[0] |=>
      icnt_q[0] == $past(cnt_reg_q[0]) && irun_q[0])
      else $error("hit did not reload idle counter");
   chk_user_trap_smi: assert property (trap_hit[1] |=>
      utrap_q[4] && top_q[9])
      else $error("user trap status missing");
   chk_idle_tick_step: assert property (irun_q[0] && sec_tick &&
      idle_en[0] && !act[0] && icnt_q[0] > 16'h0001 |=>
      icnt_q[0] == $past(icnt_q[0]) - 16'h0001)
      else $error("idle counter did not step");
   chk_io_read_gate: assert property (!ctl_q[0][7] && !ctl_q[0][5] &&
      acc_valid && !acc.write |-> !act[0])
      else $error("untracked read counted");
   chk_space_select: assert property (ctl_q[1][7] && !acc.mem |->
      !act[1])
      else $error("io cycle matched memory device");
   chk_vga_start_load: assert property (vga_rise && vst_q ==
      dit_pkg::VGA_OFF |=> vst_q == dit_pkg::VGA_RUN &&
      vcnt_q == $past(vload_q))
      else $error("vga counter not loaded");
   chk_vga_no_reload: assert property (vst_q == dit_pkg::VGA_DONE &&
      vga_en |=> vst_q == dit_pkg::VGA_DONE ##1 vst_q != dit_pkg::VGA_RUN)
      else $error("vga counter reloaded without re-enable");
   chk_vga_top_only: assert property (vga_exp && !(|idle_exp) &&
      !(|trap_hit) && !(|clr_idle) |=> top_q[6] && $stable(idle_sl_q))
      else $error("vga expiry status wrong");
   chk_idle_stop_zero: assert property (!irun_q[2] && !act[2] &&
      !irise[2] |-> !idle_exp[2])
      else $error("stopped timer raised smi");
   chk_video_trap: assert property (trap_hit[2] |=>
      trap_sl_q[7] && top_q[0])
      else $error("video trap status missing");
endmodule

// ---- dit_pkg.sv ----
package dit_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned SEC_TICK_S  = 1;
   localparam int unsigned MS_TICK_US  = 1000;
   localparam int unsigned FAST_TICK_US = 32;
   localparam int unsigned SEC_CYCLES  = CLK_HZ * SEC_TICK_S;
   localparam int unsigned MS_CYCLES   = (CLK_HZ / 1_000_000) * MS_TICK_US;
   localparam int unsigned FAST_CYCLES = (CLK_HZ / 1_000_000) * FAST_TICK_US;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EN_TWO     = 8'h81;
   localparam logic [7:0] IDX_EN_THREE   = 8'h82;
   localparam logic [7:0] IDX_EN_FOUR    = 8'h83;
   localparam logic [7:0] IDX_IDLE_STS   = 8'h85;
   localparam logic [7:0] IDX_TRAP_STS   = 8'h86;
   localparam logic [7:0] IDX_GPT2_CTL   = 8'h8B;
   localparam logic [7:0] IDX_VGA_LOAD   = 8'h8E;
   localparam logic [7:0] IDX_CNT_TWO    = 8'hA2;
   localparam logic [7:0] IDX_CNT_THREE  = 8'hA4;
   localparam logic [7:0] IDX_CNT_VIDEO  = 8'hA6;
   localparam logic [7:0] IDX_BASE_TWO   = 8'hC4;
   localparam logic [7:0] IDX_BASE_THREE = 8'hC8;
   localparam logic [7:0] IDX_CTL_TWO    = 8'hCD;
   localparam logic [7:0] IDX_CTL_THREE  = 8'hCE;
   localparam logic [7:0] IDX_TOP_STS    = 8'hF0;
   localparam logic [7:0] IDX_UDEV_TRAP  = 8'hF4;
   localparam logic [7:0] REG_RESET      = 8'h00;
   // field positions
   localparam int EN_IDLE_LSB  = 5;
   localparam int EN_VGA_BIT   = 3;
   localparam int VGA_BASE_BIT = 6;
   localparam int CTL_MEM_BIT  = 7;
   localparam int CTL_WR_BIT   = 6;
   localparam int CTL_RD_BIT   = 5;
   localparam int TOP_IDLE_BIT = 0;
   localparam int TOP_VGA_BIT  = 6;
   localparam int TOP_TRAP_BIT = 9;
   localparam int SL_IDLE_LSB  = 5;
   localparam int SL_VTRAP_BIT = 7;
   localparam int SL_UTRAP_LSB = 3;
   // standard vga decode
   localparam logic [11:0] VGA_IO_MONO  = 12'h03B;
   localparam logic [11:0] VGA_IO_ATTR  = 12'h03C;
   localparam logic [11:0] VGA_IO_COLOR = 12'h03D;
   localparam logic [31:0] VGA_MEM_LO   = 32'h000A0000;
   localparam logic [31:0] VGA_MEM_HI   = 32'h000B7FFF;

   typedef struct packed {
      logic [31:0] addr;
      logic        mem;
      logic        write;
   } dit_access_t;

   typedef enum logic [1:0] {
      VGA_OFF  = 2'b00,
      VGA_RUN  = 2'b01,
      VGA_DONE = 2'b10
   } dit_vga_state_t;
endpackage

// ---- dit_host_model.sv ----
`timescale 1ns/10ps
module dit_host_model (
   input  wire logic            sys_clk,
   output logic                 acc_valid,
   output dit_pkg::dit_access_t acc,
   output logic                 processor_serial_activity
);
   initial
   begin
      acc_valid = 1'b0;
      acc = '0;
      processor_serial_activity = 1'b0;
   end

   // one monitored host cycle, a single-clock pulse
   task automatic cycle(input logic [31:0] a, input logic m, input logic w);
      @(posedge sys_clk);
      acc_valid <= 1'b1;
      acc <= '{addr: a, mem: m, write: w};
      @(posedge sys_clk);
      acc_valid <= 1'b0;
      // stale fields are inverted so a late sample never looks like a hit
      acc <= '{addr: ~a, mem: ~m, write: ~w};
   endtask

   // embedded graphics activity shown on the serial bit
   task automatic serial_pulse();
      @(posedge sys_clk);
      processor_serial_activity <= 1'b1;
      repeat (4) @(posedge sys_clk);
      processor_serial_activity <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   logic                 sys_clk;
   logic                 rst;
   logic [9:0]           avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [31:0]          avs_writedata;
   logic [31:0]          avs_readdata;
   logic                 avs_waitrequest;
   logic                 acc_valid;
   dit_pkg::dit_access_t acc;
   logic                 psa;
   logic                 smi_active;
   int                   errors;
   int                   comparisons;

   dit_idle_trap #(.SEC_CYCLES(40), .MS_CYCLES(20)) i_dut (
      .sys_clk                   (sys_clk),
      .rst                       (rst),
      .avs_address               (avs_address),
      .avs_read                  (avs_read),
      .avs_write                 (avs_write),
      .avs_byteenable            (4'hF),
      .avs_writedata             (avs_writedata),
      .avs_readdata              (avs_readdata),
      .avs_waitrequest           (avs_waitrequest),
      .acc_valid                 (acc_valid),
      .acc                       (acc),
      .processor_serial_activity (psa),
      .smi_active                (smi_active)
   );
   dit_host_model i_host (
      .sys_clk                   (sys_clk),
      .acc_valid                 (acc_valid),
      .acc                       (acc),
      .processor_serial_activity (psa)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // request stands until a rising edge sees waitrequest low; that edge
   // commits a write and is where read data is taken
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= {i, 2'b00};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask
   task automatic ck(input logic [7:0] i, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      `CHK(n, e, q)
   endtask
   task automatic poll(input logic [7:0] i, input int b, input int lim);
      logic [31:0] q;
      q = '0;
      for (int k = 0; k < lim && q[b] !== 1'b1; k++) bus(1'b0, i, 32'h0, q);
      `CHK("poll", 1'b1, q[b])
   endtask
   task automatic clr();
      wr(8'hF0, 32'hFFFFFFFF);
      wr(8'hF4, 32'hFFFFFFFF);
      wr(8'h85, 32'hFFFFFFFF);
      wr(8'h86, 32'hFFFFFFFF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] idx [12] = '{8'h81, 8'h82, 8'h83, 8'h8B, 8'hA2, 8'hA4,
                               8'hA6, 8'hC4, 8'hC8, 8'hCD, 8'hCE, 8'hF0};
      foreach (idx[k]) ck(idx[k], 32'h0, "reset");
      `CHK("smi", 1'b0, smi_active)
      wr(8'h10, 32'hFFFFFFFF);
      ck(8'h10, 32'h0, "unmapped");
      wr(8'hC4, 32'hA5A55A5A);
      ck(8'hC4, 32'hA5A55A5A, "base");
      $display("reset test done");
   endtask
   task automatic t_io_trap();
      wr(8'hC4, 32'h00000300);
      wr(8'hCD, 32'h47);
      wr(8'h82, 32'h20);
      i_host.cycle(32'h305, 1'b0, 1'b0);
      ck(8'hF4, 32'h0, "rd untracked");
      i_host.cycle(32'h305, 1'b0, 1'b1);
      ck(8'hF4, 32'h8, "trap2");
      ck(8'hF0, 32'h200, "top");
      `CHK("smi", 1'b1, smi_active)
      clr();
      i_host.cycle(32'h30D, 1'b0, 1'b1);
      i_host.cycle(32'h300, 1'b1, 1'b1);
      ck(8'hF4, 32'h0, "no hit");
      $display("io trap test done");
   endtask
   task automatic t_mem_trap();
      wr(8'hC8, 32'h12340000);
      wr(8'hCE, 32'h81);
      wr(8'h82, 32'h40);
      i_host.cycle(32'h123403FF, 1'b1, 1'b0);
      ck(8'hF4, 32'h10, "trap3");
      ck(8'hF0, 32'h200, "top");
      clr();
      i_host.cycle(32'h12340400, 1'b1, 1'b0);
      ck(8'hF4, 32'h0, "a10 miss");
      wr(8'h82, 32'h0);
      $display("memory trap test done");
   endtask
   task automatic t_idle();
      wr(8'hC4, 32'h00000300);
      wr(8'hCD, 32'h60);
      wr(8'hA2, 32'h3);
      // device three sees no hits, so it expires at its first tick
      wr(8'hA4, 32'h1);
      wr(8'h81, 32'h60);
      repeat (10)
      begin
         i_host.cycle(32'h300, 1'b0, 1'b0);
         repeat (30) @(posedge sys_clk);
      end
      ck(8'h85, 32'h40, "reloaded");
      poll(8'h85, 5, 100);
      ck(8'hF0, 32'h1, "top idle");
      clr();
      repeat (200) @(posedge sys_clk);
      ck(8'h85, 32'h0, "stopped");
      wr(8'h81, 32'h0);
      $display("idle test done");
   endtask
   task automatic t_video();
      wr(8'h82, 32'h80);
      i_host.serial_pulse();
      ck(8'h86, 32'h80, "vtrap pin");
      ck(8'hF0, 32'h1, "top");
      clr();
      i_host.cycle(32'h3D4, 1'b0, 1'b1);
      ck(8'h86, 32'h80, "vtrap io");
      clr();
      i_host.cycle(32'h000B8000, 1'b1, 1'b0);
      ck(8'h86, 32'h0, "out of range");
      wr(8'h82, 32'h0);
      wr(8'hA6, 32'h2);
      wr(8'h81, 32'h80);
      poll(8'h85, 7, 100);
      clr();
      wr(8'h81, 32'h0);
      $display("video test done");
   endtask
   task automatic t_vga();
      wr(8'h8E, 32'h3);
      wr(8'h83, 32'h08);
      poll(8'hF0, 6, 60);
      ck(8'h85, 32'h0, "no second level");
      clr();
      wr(8'h8E, 32'h2);
      repeat (150) @(posedge sys_clk);
      ck(8'hF0, 32'h0, "no reload");
      // disable, rewrite, re-enable; global enable stays clear
      wr(8'h83, 32'h0);
      wr(8'h8B, 32'h40);
      wr(8'h83, 32'h08);
      repeat (100) @(posedge sys_clk);
      ck(8'hF0, 32'h0, "slow base");
      poll(8'hF0, 6, 700);
      $display("vga test done");
   endtask

   task automatic summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      errors = 0;
      comparisons = 0;
      rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_io_trap();
      t_mem_trap();
      t_idle();
      t_video();
      t_vga();
      summarize();
   end

   // all tests fit well inside this span
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      summarize();
   end
endmodule
